// *** channel_selection_tag_handshake_tb_top.sv ***
// Self-checking bench for the control-unit selection and tag block
`timescale 1ns/1ns
`include "cstag_params.svh"
module channel_selection_tag_handshake_tb_top;
    import cstag_pkg::*;
    logic mclk, rst_n, cfg_ret_leg, sel_a_i, sel_b_i, sel_a_o, sel_b_o, hold_out, req_in;
    logic addr_out, cmd_out, svc_out, sup_out, op_in, addr_in, stat_in, svc_in;
    cstag_bus_t bus_out, bus_in;
    logic dev_req, dev_busy, rd_vld, rd_ack, wr_req, wr_vld, end_vld, end_ack;
    logic [7:0] rd_byte, wr_byte, end_status, cmd_byte;
    logic cmd_vld, stop, stat_acc, stat_pend, halted, ok;
    logic [1:0] rc;
    logic [5:0] seen;
    int num_errors, checked, n;
    cstag_cu #(.DEV_ADDR(`CSTAG_DEV_ADDR)) uut (.mclk, .rst_n, .cfg_ret_leg, .sel_a_i,
        .sel_b_i, .sel_a_o, .sel_b_o, .hold_out, .req_in, .addr_out, .cmd_out, .svc_out,
        .sup_out, .bus_out, .op_in, .addr_in, .stat_in, .svc_in, .bus_in, .dev_req,
        .dev_busy, .rd_vld, .rd_byte, .rd_ack, .wr_req, .wr_vld, .wr_byte, .end_vld,
        .end_status, .end_ack, .cmd_vld, .cmd_byte, .stop, .stat_acc, .stat_pend, .halted);
    cstag_chan_model ch (.mclk, .sel_o(sel_a_i), .hold_out, .addr_out, .cmd_out, .svc_out,
        .sup_out, .bus_out, .sel_in(sel_a_o), .op_in, .addr_in, .stat_in, .svc_in, .bus_in);
    always #5 mclk = ~mclk;
    // Sticky copy of the one-cycle pulses, sampled clear of the edge
    always @(posedge mclk) #1 seen = seen | {cmd_vld, rd_ack, wr_vld, stop, stat_acc, end_ack};
    task automatic stop_test;
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic chk1(input logic g, input logic e);
        chk({8'h00, g}, {8'h00, e});
    endtask : chk1
    task automatic wseen(input int b);
        for (int i = 0; i < 200 && seen[b] !== 1'b1; i++)
            @(negedge mclk);
        chk1(seen[b], 1'b1);
    endtask : wseen
    task automatic connect(input logic [7:0] c);
        seen = '0;
        ch.select_unit(`CSTAG_DEV_ADDR, rc);
        chk1(rc === 2'd1 && addr_in, 1'b1);
        chk(bus_in, {`CSTAG_DEV_ADDR, ~^`CSTAG_DEV_ADDR});
        ch.reply(1'b1, c, ok);
        chk1(ok, 1'b1);
        wseen(5);
        chk({1'b0, cmd_byte}, {1'b0, c});
    endtask : connect
    task automatic t_leg_b;
        sel_b_i = 1'b1;
        repeat (8) @(negedge mclk);
        chk1(sel_b_o, 1'b1);
        sel_b_i = 1'b0;
        repeat (8) @(negedge mclk);
        chk1(sel_b_o, 1'b0);
        cfg_ret_leg = 1'b1;
        sel_b_i = 1'b1;
        repeat (8) @(negedge mclk);
        chk1(sel_b_o && !op_in && !sel_a_o, 1'b1);
        sel_b_i = 1'b0;
        repeat (8) @(negedge mclk);
        chk1(sel_b_o, 1'b0);
        cfg_ret_leg = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : t_leg_b
    task automatic t_mismatch;
        ch.select_unit(8'h3c, rc);
        chk1(rc === 2'd2 && !op_in, 1'b1);
        ch.drop_sel(ok);
        chk1(ok, 1'b1);
    endtask : t_mismatch
    task automatic t_busy;
        dev_busy = 1'b1;
        ch.select_unit(`CSTAG_DEV_ADDR, rc);
        chk1(rc === 2'd3, 1'b1);
        chk(ch.got, {`CSTAG_BUSY_STAT, ~^`CSTAG_BUSY_STAT});
        ch.drop_sel(ok);
        dev_busy = 1'b0;
    endtask : t_busy
    task automatic t_transfer;
        connect(8'h06);
        seen = '0;
        rd_byte = 8'hc3;
        rd_vld = 1'b1;
        ch.reply(1'b0, 8'h00, ok);
        rd_vld = 1'b0;
        chk(ch.got, {8'hc3, ~^8'hc3});
        wseen(4);
        wr_req = 1'b1;
        ch.reply(1'b0, 8'h5a, ok);
        wr_req = 1'b0;
        wseen(3);
        chk({1'b0, wr_byte}, 9'h05a);
        rd_vld = 1'b1;
        ch.reply(1'b1, 8'h00, ok);
        rd_vld = 1'b0;
        wseen(2);
        end_status = 8'h0c;
        end_vld = 1'b1;
        ch.reply(1'b0, 8'h00, ok);
        chk(ch.got, {8'h0c, ~^8'h0c});
        wseen(1);
        wseen(0);
        end_vld = 1'b0;
        ch.drop_sel(ok);
        chk1(ok, 1'b1);
    endtask : t_transfer
    task automatic t_stack;
        dev_req = 1'b1;
        repeat (10) @(negedge mclk);
        chk1(req_in, 1'b1);
        ch.poll(1'b0, 1'b0, rc);
        chk1(rc === 2'd2 && !op_in, 1'b1);
        ch.drop_sel(ok);
        seen = '0;
        ch.poll(1'b1, 1'b0, rc);
        chk1(rc === 2'd1, 1'b1);
        dev_req = 1'b0;
        ch.reply(1'b1, 8'h06, ok);
        chk1(seen[5], 1'b0);
        end_status = 8'h0c;
        end_vld = 1'b1;
        ch.reply(1'b1, 8'h00, ok);
        wseen(0);
        end_vld = 1'b0;
        chk1(stat_pend, 1'b1);
        ch.drop_sel(ok);
        ch.poll(1'b1, 1'b1, rc);
        chk1(rc === 2'd2, 1'b1);
        ch.drop_sel(ok);
        ch.select_unit(8'h3c, rc);
        chk1(rc === 2'd2, 1'b1);
        ch.drop_sel(ok);
        seen = '0;
        ch.poll(1'b1, 1'b0, rc);
        chk1(rc === 2'd1, 1'b1);
        ch.reply(1'b1, 8'h00, ok);
        ch.reply(1'b0, 8'h00, ok);
        chk(ch.got, {8'h0c, ~^8'h0c});
        wseen(1);
        ch.drop_sel(ok);
        chk1(stat_pend, 1'b0);
    endtask : t_stack
    task automatic t_halt;
        connect(8'h02);
        ch.halt(n);
        chk1(n < 600, 1'b1);
        chk1(halted, 1'b1);
        seen = '0;
        rd_vld = 1'b1;
        wseen(4);
        rd_vld = 1'b0;
        chk1(svc_in, 1'b0);
        end_vld = 1'b1;
        repeat (20) @(negedge mclk);
        end_vld = 1'b0;
        chk1(stat_pend && !halted && !stat_in, 1'b1);
        ch.drop_sel(ok);
    endtask : t_halt
    initial
    begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        stop_test;
    end
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {cfg_ret_leg, sel_b_i, dev_req, dev_busy, rd_vld, wr_req, end_vld} = 7'h00;
        {rd_byte, end_status} = 16'h0000;
        num_errors = 0;
        checked = 0;
        seen = '0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_leg_b;
        t_mismatch;
        t_busy;
        t_transfer;
        t_stack;
        t_halt;
        stop_test;
    end
endmodule : channel_selection_tag_handshake_tb_top

// *** cstag_chan_model.sv ***
// Behavioural channel driving the selection loop and outbound tags
`timescale 1ns/1ns
module cstag_chan_model
    import cstag_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Outbound lines
    output logic sel_o,
    output logic hold_out,
    output logic addr_out,
    output logic cmd_out,
    output logic svc_out,
    output logic sup_out,
    output cstag_bus_t bus_out,
    // Inbound lines
    input wire logic sel_in,
    input wire logic op_in,
    input wire logic addr_in,
    input wire logic stat_in,
    input wire logic svc_in,
    input wire cstag_bus_t bus_in
);
    cstag_bus_t got;
    initial
    begin
        {sel_o, hold_out, addr_out, cmd_out, svc_out, sup_out} = 6'h00;
        bus_out = 9'h0aa;
        got = 9'h000;
    end
    // Bounded wait on the OR of the masked inbound lines
    task automatic wait_in(input logic [4:0] m, input logic v, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 1500 && !ok; i++)
        begin
            @(negedge mclk);
            ok = ((|(m & {sel_in, op_in, addr_in, stat_in, svc_in})) === v);
        end
    endtask : wait_in
    // Result: 0 no answer, 1 op-in, 2 select-in, 3 busy status
    task automatic select_unit(input logic [7:0] a, output logic [1:0] rc);
        logic ok;
        @(negedge mclk);
        bus_out = {a, ~^a};
        addr_out = 1'b1;
        repeat (41) @(negedge mclk);
        hold_out = 1'b1;
        sel_o = 1'b1;
        wait_in(5'b11010, 1'b1, ok);
        rc = !ok ? 2'd0 : op_in ? 2'd1 : sel_in ? 2'd2 : 2'd3;
        if (rc == 2'd3)
        begin
            got = bus_in;
            sel_o = 1'b0;
            wait_in(5'b00010, 1'b0, ok);
            if (!ok)
                rc = 2'd0;
        end
        addr_out = 1'b0;
        bus_out = ~bus_out;
    endtask : select_unit
    // Poll without address-out; may be withheld until request-in
    task automatic poll(input logic hold, input logic sup, output logic [1:0] rc);
        logic ok;
        @(negedge mclk);
        sup_out = sup;
        hold_out = hold;
        sel_o = 1'b1;
        wait_in(5'b11000, 1'b1, ok);
        rc = !ok ? 2'd0 : op_in ? 2'd1 : 2'd2;
    endtask : poll
    // Answer the standing inbound tag with command-out or service-out
    task automatic reply(input logic cmd, input logic [7:0] d, output logic ok);
        logic ok2;
        wait_in(5'b00111, 1'b1, ok);
        got = bus_in;
        bus_out = {d, ~^d};
        @(negedge mclk);
        cmd_out = cmd;
        svc_out = !cmd;
        wait_in(5'b00111, 1'b0, ok2);
        {cmd_out, svc_out} = 2'b00;
        bus_out = ~bus_out;
        ok = ok & ok2;
    endtask : reply
    task automatic drop_sel(output logic ok);
        @(negedge mclk);
        {sel_o, hold_out, sup_out} = 3'b000;
        wait_in(5'b11000, 1'b0, ok);
    endtask : drop_sel
    // Disconnect a connected unit; n counts cycles until op-in falls
    task automatic halt(output int n);
        @(negedge mclk);
        addr_out = 1'b1;
        @(negedge mclk);
        sel_o = 1'b0;
        n = 0;
        while (op_in && n < 1500)
        begin
            @(negedge mclk);
            n++;
        end
        addr_out = 1'b0;
    endtask : halt
endmodule : cstag_chan_model

// *** cstag_cu.sv ***
// Control-unit end of the channel selection loop and tag handshakes
`timescale 1ns/1ns
`include "cstag_params.svh"
module cstag_cu
    import cstag_pkg::*;
#(
    parameter logic [7:0] DEV_ADDR = `CSTAG_DEV_ADDR
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Static option: selection logic on the return leg
    input wire logic cfg_ret_leg,
    // Selection loop
    input wire logic sel_a_i,
    input wire logic sel_b_i,
    output logic sel_a_o,
    output logic sel_b_o,
    input wire logic hold_out,
    output logic req_in,
    // Outbound tags and bus
    input wire logic addr_out,
    input wire logic cmd_out,
    input wire logic svc_out,
    input wire logic sup_out,
    input wire logic [0:8] bus_out,
    // Inbound tags and bus
    output logic op_in,
    output logic addr_in,
    output logic stat_in,
    output logic svc_in,
    output logic [0:8] bus_in,
    // Device side requests
    input wire logic dev_req,
    input wire logic dev_busy,
    input wire logic rd_vld,
    input wire logic [7:0] rd_byte,
    output logic rd_ack,
    input wire logic wr_req,
    output logic wr_vld,
    output logic [7:0] wr_byte,
    input wire logic end_vld,
    input wire logic [7:0] end_status,
    output logic end_ack,
    // Device side events
    output logic cmd_vld,
    output logic [7:0] cmd_byte,
    output logic stop,
    output logic stat_acc,
    output logic stat_pend,
    output logic halted
);
    logic [`CSTAG_SYNC_W-1:0] sync_q;
    logic sel_a_s, sel_b_s, hold_s, addr_s, cmd_s, svc_s, sup_s;
    cstag_bus_t bus_s;
    logic sel_l, match, fresh;
    cstag_state_e state_r, state_nxt;
    logic passed_r, passed_nxt, chan_r, chan_nxt, end_r, end_nxt, dir_r, dir_nxt;
    logic sel_a_r, sel_a_nxt, sel_b_r, sel_b_nxt, req_r, req_nxt;
    logic op_r, op_nxt, ai_r, ai_nxt, si_r, si_nxt, vi_r, vi_nxt;
    cstag_bus_t bus_in_r, bus_in_nxt;
    logic rd_ack_r, rd_ack_nxt, wr_vld_r, wr_vld_nxt, end_ack_r, end_ack_nxt;
    logic [7:0] wr_byte_r, wr_byte_nxt, cmd_byte_r, cmd_byte_nxt;
    logic [7:0] stat_byte_r, stat_byte_nxt;
    logic cmd_vld_r, cmd_vld_nxt, stop_r, stop_nxt, acc_r, acc_nxt;
    logic pend_r, pend_nxt, halt_r, halt_nxt;

    cstag_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d({sel_a_i, sel_b_i, hold_out, addr_out, cmd_out, svc_out, sup_out, bus_out}),
        .q(sync_q)
    );
    assign {sel_a_s, sel_b_s, hold_s, addr_s, cmd_s, svc_s, sup_s, bus_s} = sync_q;

    assign sel_l = cfg_ret_leg ? sel_b_s : sel_a_s;
    assign match = addr_s && (bus_s[0:7] == DEV_ADDR);
    // Only a fresh select edge with hold-out may be used
    assign fresh = sel_l && hold_s && !passed_r;

    function automatic cstag_bus_t with_par(input logic [7:0] b);
        with_par = {b, ~^b};
    endfunction : with_par

    always_comb
    begin
        state_nxt = state_r;
        passed_nxt = passed_r;
        chan_nxt = chan_r;
        end_nxt = end_r;
        dir_nxt = dir_r;
        op_nxt = op_r;
        ai_nxt = ai_r;
        si_nxt = si_r;
        vi_nxt = vi_r;
        bus_in_nxt = bus_in_r;
        wr_byte_nxt = wr_byte_r;
        cmd_byte_nxt = cmd_byte_r;
        stat_byte_nxt = stat_byte_r;
        pend_nxt = pend_r;
        halt_nxt = halt_r;
        rd_ack_nxt = 1'b0;
        wr_vld_nxt = 1'b0;
        end_ack_nxt = 1'b0;
        cmd_vld_nxt = 1'b0;
        stop_nxt = 1'b0;
        acc_nxt = 1'b0;
        case (state_r)
            S_IDLE:
            begin
                // Disconnected operation runs on with no interface traffic
                if (halt_r)
                begin
                    rd_ack_nxt = rd_vld && !rd_ack_r;
                    wr_vld_nxt = wr_req && !wr_vld_r;
                    wr_byte_nxt = 8'h00;
                    if (end_vld && !end_ack_r)
                    begin
                        end_ack_nxt = 1'b1;
                        stat_byte_nxt = end_status;
                        pend_nxt = 1'b1;
                        halt_nxt = 1'b0;
                    end
                end
                if (fresh && match && (dev_busy || halt_r))
                begin
                    si_nxt = 1'b1;
                    bus_in_nxt = with_par(`CSTAG_BUSY_STAT);
                    state_nxt = S_BUSY;
                end
                else if (fresh && match)
                begin
                    op_nxt = 1'b1;
                    ai_nxt = 1'b1;
                    chan_nxt = 1'b1;
                    bus_in_nxt = with_par(DEV_ADDR);
                    state_nxt = S_OPSEL;
                end
                else if (fresh && !addr_s && !sup_s && (dev_req || pend_r))
                begin
                    op_nxt = 1'b1;
                    ai_nxt = 1'b1;
                    chan_nxt = 1'b0;
                    bus_in_nxt = with_par(DEV_ADDR);
                    state_nxt = S_OPSEL;
                end
            end
            S_BUSY:
                if (!sel_l)
                begin
                    si_nxt = 1'b0;
                    state_nxt = S_IDLE;
                end
            S_OPSEL:
                if (cmd_s)
                begin
                    if (chan_r)
                    begin
                        cmd_byte_nxt = bus_s[0:7];
                        cmd_vld_nxt = 1'b1;
                    end
                    ai_nxt = 1'b0;
                    end_nxt = 1'b0;
                    state_nxt = S_DROP;
                end
            S_CONN:
                if (addr_s)
                begin
                    op_nxt = 1'b0;
                    halt_nxt = 1'b1;
                    state_nxt = S_IDLE;
                end
                else if (pend_r && !chan_r)
                begin
                    si_nxt = 1'b1;
                    bus_in_nxt = with_par(stat_byte_r);
                    state_nxt = S_STAT;
                end
                else if (end_vld && !end_ack_r)
                begin
                    end_ack_nxt = 1'b1;
                    stat_byte_nxt = end_status;
                    si_nxt = 1'b1;
                    bus_in_nxt = with_par(end_status);
                    state_nxt = S_STAT;
                end
                else if (rd_vld && !rd_ack_r)
                begin
                    vi_nxt = 1'b1;
                    dir_nxt = 1'b0;
                    bus_in_nxt = with_par(rd_byte);
                    state_nxt = S_SVC;
                end
                else if (wr_req && !wr_vld_r)
                begin
                    vi_nxt = 1'b1;
                    dir_nxt = 1'b1;
                    state_nxt = S_SVC;
                end
            S_SVC:
                if (addr_s)
                begin
                    op_nxt = 1'b0;
                    vi_nxt = 1'b0;
                    halt_nxt = 1'b1;
                    state_nxt = S_IDLE;
                end
                else if (cmd_s)
                begin
                    stop_nxt = 1'b1;
                    vi_nxt = 1'b0;
                    state_nxt = S_DROP;
                end
                else if (svc_s)
                begin
                    rd_ack_nxt = !dir_r;
                    wr_vld_nxt = dir_r;
                    wr_byte_nxt = bus_s[0:7];
                    vi_nxt = 1'b0;
                    state_nxt = S_DROP;
                end
            S_STAT:
                if (addr_s)
                begin
                    op_nxt = 1'b0;
                    si_nxt = 1'b0;
                    pend_nxt = 1'b1;
                    halt_nxt = 1'b1;
                    state_nxt = S_IDLE;
                end
                else if (cmd_s || svc_s)
                begin
                    pend_nxt = cmd_s;
                    acc_nxt = svc_s;
                    si_nxt = 1'b0;
                    end_nxt = 1'b1;
                    state_nxt = S_DROP;
                end
            S_DROP:
                if (addr_s && !chan_r)
                begin
                    op_nxt = 1'b0;
                    halt_nxt = !end_r;
                    state_nxt = S_IDLE;
                end
                else if (!cmd_s && !svc_s)
                begin
                    chan_nxt = 1'b0;
                    state_nxt = end_r ? S_END : S_CONN;
                end
            S_END:
                // Op-in may not fall before the channel drops select-out
                if (!sel_l)
                begin
                    op_nxt = 1'b0;
                    state_nxt = S_IDLE;
                end
            default:
                state_nxt = S_IDLE;
        endcase
        passed_nxt = sel_l && (passed_r || (state_r == S_IDLE && state_nxt == S_IDLE));
        sel_a_nxt = cfg_ret_leg ? sel_a_s : passed_nxt;
        sel_b_nxt = cfg_ret_leg ? passed_nxt : sel_b_s;
        req_nxt = (dev_req || pend_nxt) && state_nxt == S_IDLE;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_r <= S_IDLE;
            {passed_r, chan_r, end_r, dir_r, sel_a_r, sel_b_r, req_r} <= 7'h00;
            {op_r, ai_r, si_r, vi_r} <= 4'h0;
            bus_in_r <= 9'h001;
            {wr_byte_r, cmd_byte_r, stat_byte_r} <= 24'h000000;
            {rd_ack_r, wr_vld_r, end_ack_r, cmd_vld_r, stop_r, acc_r} <= 6'h00;
            {pend_r, halt_r} <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            {passed_r, chan_r, end_r, dir_r} <= {passed_nxt, chan_nxt, end_nxt, dir_nxt};
            {sel_a_r, sel_b_r, req_r} <= {sel_a_nxt, sel_b_nxt, req_nxt};
            {op_r, ai_r, si_r, vi_r} <= {op_nxt, ai_nxt, si_nxt, vi_nxt};
            bus_in_r <= bus_in_nxt;
            {wr_byte_r, cmd_byte_r, stat_byte_r} <= {wr_byte_nxt, cmd_byte_nxt, stat_byte_nxt};
            {rd_ack_r, wr_vld_r, end_ack_r} <= {rd_ack_nxt, wr_vld_nxt, end_ack_nxt};
            {cmd_vld_r, stop_r, acc_r} <= {cmd_vld_nxt, stop_nxt, acc_nxt};
            {pend_r, halt_r} <= {pend_nxt, halt_nxt};
        end
    end

    assign {sel_a_o, sel_b_o, req_in} = {sel_a_r, sel_b_r, req_r};
    assign {op_in, addr_in, stat_in, svc_in, bus_in} = {op_r, ai_r, si_r, vi_r, bus_in_r};
    assign {rd_ack, wr_vld, wr_byte, end_ack} = {rd_ack_r, wr_vld_r, wr_byte_r, end_ack_r};
    assign {cmd_vld, cmd_byte, stop, stat_acc} = {cmd_vld_r, cmd_byte_r, stop_r, acc_r};
    assign {stat_pend, halted} = {pend_r, halt_r};

    // Helper: cycles op-in stays up under a disconnect request
    logic [9:0] disc_cnt_r;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            disc_cnt_r <= 10'h000;
        else if (op_r && addr_s && state_r != S_OPSEL)
            disc_cnt_r <= disc_cnt_r + 10'h001;
        else
            disc_cnt_r <= 10'h000;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence svc_asked;
        vi_r && (svc_s || cmd_s) && !addr_s;
    endsequence
    sequence svc_dropped;
        !vi_r ##1 1'b1;
    endsequence

    pass_block_a: assert property ((op_r || si_r) |-> !passed_r)
        else $error("select passed while holding the interface");
    hold_gate_a: assert property ($rose(op_r) |-> $past(hold_s))
        else $error("select used without hold-out");
    one_inbound_a: assert property ($onehot0({ai_r, si_r, vi_r}))
        else $error("two inbound tags up");
    svc_drop_a: assert property (svc_asked |=> svc_dropped)
        else $error("service-in not dropped after answer");
    disc_time_a: assert property (disc_cnt_r < `CSTAG_HALT_CYC)
        else $error("op-in held too long after disconnect");
    cmd_decode_a: assert property (cmd_vld_r |-> $past(state_r == S_OPSEL && chan_r && cmd_s))
        else $error("command decoded outside selection");
    stop_cause_a: assert property (stop_r |-> $past(state_r == S_SVC && cmd_s))
        else $error("stop without command-out on service-in");
    stack_hold_a: assert property ((state_r == S_STAT && cmd_s && !addr_s) |=> pend_r)
        else $error("status not stacked");
    stat_offer_a: assert property ($rose(op_r) && !chan_nxt |-> $past(!sup_s && !addr_s))
        else $error("status offered with suppress or address up");
    wr_capture_a: assert property (wr_vld_r && !$past(halt_r) |-> wr_byte_r == $past(bus_s[0:7]))
        else $error("write byte not taken from bus-out");
    busy_answer_a: assert property ($rose(si_r) && !op_r |-> $past(match) ##1 si_r)
        else $error("busy answer malformed");
    parity_a: assert property (bus_in_r[`CSTAG_PAR_BIT] == ~^bus_in_r[0:7])
        else $error("bus-in parity not odd");
endmodule : cstag_cu

// *** cstag_params.svh ***
// Constants for the channel selection and tag handshake block
// Behaviour
// - Last unit's outgoing select-out returns as select-in, same definition.
// - Option places selection logic on the select-out or select-in leg.
// - Request-in means the unit starts a sequence at its next poll.
// - Without hold-out, select-out is only passed on, never used.
// - On address-out, a matching idle unit raises operational-in at select.
// - Busy unit answers address-out with status-in until select-out falls.
// - On disconnect the unit drops operational-in within 6 us; in S_OPSEL the code holds it until command-out.
// - After disconnect the operation ends internally, no data crosses.
// - Command byte decoded only on command-out answering address-in.
// - Command-out answering service-in is a stop.
// - Command-out answering status-in stacks the status byte.
// - Stacked status offered only if suppress-out and address-out are low.
// - Read data and status may be released at service-out rise.
// - Write data on bus-out is captured at service-out rise.
// - Buses carry eight bits, bit 0 most significant, plus odd parity.
// - On select-out the unit either takes the interface or passes it on.
// - Each inbound tag is held until answered, then dropped.
`ifndef CSTAG_PARAMS_SVH
`define CSTAG_PARAMS_SVH
`define CSTAG_DEV_ADDR 8'h10
`define CSTAG_BUSY_STAT 8'h10
`define CSTAG_PAR_BIT 8
`define CSTAG_SYNC_W 16
`define CSTAG_CLK_NS 10
`define CSTAG_HALT_NS 6000
`define CSTAG_HALT_CYC (`CSTAG_HALT_NS / `CSTAG_CLK_NS)
`endif

// *** cstag_pkg.sv ***
// Types for the channel selection and tag handshake block
package cstag_pkg;
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_BUSY  = 8'h02,
        S_OPSEL = 8'h04,
        S_CONN  = 8'h08,
        S_SVC   = 8'h10,
        S_STAT  = 8'h20,
        S_DROP  = 8'h40,
        S_END   = 8'h80
    } cstag_state_e;
    typedef logic [0:8] cstag_bus_t;
endpackage : cstag_pkg

// *** cstag_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`include "cstag_params.svh"
module cstag_sync
    import cstag_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Asynchronous inputs and their clean copies
    input wire logic [`CSTAG_SYNC_W-1:0] d,
    output logic [`CSTAG_SYNC_W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < `CSTAG_SYNC_W; i = i + 1)
        begin : g_bit
            // Per-bit stages keep one writing process per variable
            logic s1_r, s2_r, s3_r, q_r;
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    q_r <= 1'b0;
                end
                else
                begin
                    s1_r <= d[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    // A change counts only once two late stages agree
                    if (s2_r == s3_r)
                        q_r <= s3_r;
                end
            end
            assign q[i] = q_r;
        end
    endgenerate
endmodule : cstag_sync
